// ---- rtl/alpic_top.sv ----
// module: converter control with wishbone registers, low power and interrupt
//
// Local design decisions: the register offsets and register access over Wishbone.
`default_nettype none
module alpic_top
  import alpic_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [7:0]       wb_adr_in,
  input  wire logic [31:0]      wb_dat_in,
  input  wire logic [3:0]       wb_sel_in,
  output logic                  wb_ack_out,
  output logic      [31:0]      wb_dat_out,
  input  wire logic             wait_mode_in,
  input  wire logic             stop_mode_in,
  input  wire logic             external_trigger_input_in,
  input  wire logic [RES_W-1:0] sample_data_in,
  output logic                  irq_out,
  output logic                  low_power_out,
  output logic                  conv_active_out,
  output logic      [CH_W-1:0]  channel_select_out
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_q, rst_b_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_q <= 1'b0;
      rst_b_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q  <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external trigger synchroniser and rise detect
  logic trg_s1_q, trg_s2_q, trg_s3_q, trg_lvl_q, trg_lvl_d;
  logic trig_rise_w;
  always_comb begin
    trg_lvl_d   = (trg_s2_q == trg_s3_q) ? trg_s2_q : trg_lvl_q;
    trig_rise_w = trg_lvl_d & ~trg_lvl_q;
  end
  always_ff @(posedge clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      trg_s1_q  <= 1'b0;
      trg_s2_q  <= 1'b0;
      trg_s3_q  <= 1'b0;
      trg_lvl_q <= 1'b0;
    end else begin
      trg_s1_q  <= external_trigger_input_in;
      trg_s2_q  <= trg_s1_q;
      trg_s3_q  <= trg_s2_q;
      trg_lvl_q <= trg_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state
  alpic_state_t     st_q, st_d;
  logic             flag_q, flag_d;
  logic             ien_q, ien_d;
  logic             cont_q, cont_d;
  logic [CH_W-1:0]  ch_q, ch_d;
  logic             aclk_q, aclk_d;
  logic             ext_q, ext_d;
  logic             halted_q, halted_d;
  logic [IST_W-1:0] ists_q, ists_d;
  logic [IST_W-1:0] imsk_q, imsk_d;
  logic [RES_W-1:0] res_q, res_d;
  logic             irq_q, irq_d;
  logic             lp_q, lp_d;
  logic             act_q, act_d;
  logic             ack_q, ack_d;
  logic [31:0]      rdat_q, rdat_d;
  logic             tmr_start_w, tmr_abort_w, tmr_done_w;
  logic             req_w, wr_w, sc_wr_w, resl_rd_w;
  logic             stop_abort_w, sw_start_w, hw_start_w;

  alpic_conv_timer #(
    .CYCLES (CONV_CYCLES)
  ) u_timer (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_q),
    .start_in (tmr_start_w),
    .abort_in (tmr_abort_w),
    .busy_out (),
    .done_out (tmr_done_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and read mux
  always_comb begin
    req_w     = wb_cyc_in & wb_stb_in;
    wr_w      = req_w & wb_we_in & ack_q & wb_sel_in[0];
    sc_wr_w   = wr_w && (wb_adr_in == ADDR_SC);
    resl_rd_w = req_w & ~wb_we_in & ack_q & (wb_adr_in == ADDR_RESL);
    ack_d     = req_w & ~ack_q;
    rdat_d    = 32'h0000_0000;
    if (ack_d && !wb_we_in) begin
      case (wb_adr_in)
        ADDR_SC: begin
          rdat_d[SC_FLAG_BIT] = flag_q;
          rdat_d[SC_IEN_BIT]  = ien_q;
          rdat_d[SC_CONT_BIT] = cont_q;
          rdat_d[CH_W-1:0]    = ch_q;
        end
        ADDR_RESH: rdat_d[RES_W-9:0] = res_q[RES_W-1:8];
        ADDR_RESL: rdat_d[7:0] = res_q[7:0];
        ADDR_CFG: begin
          rdat_d[CFG_ACLK_BIT] = aclk_q;
          rdat_d[CFG_EXT_BIT]  = ext_q;
        end
        ADDR_ISTS: rdat_d[IST_W-1:0] = ists_q;
        ADDR_IMSK: rdat_d[IST_W-1:0] = imsk_q;
        default:   rdat_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion control, flags and interrupt
  always_comb begin
    st_d        = st_q;
    flag_d      = flag_q;
    ien_d       = ien_q;
    cont_d      = cont_q;
    ch_d        = ch_q;
    aclk_d      = aclk_q;
    ext_d       = ext_q;
    halted_d    = halted_q;
    ists_d      = ists_q;
    imsk_d      = imsk_q;
    res_d       = res_q;
    tmr_start_w = 1'b0;
    tmr_abort_w = 1'b0;
    // stop only aborts when the converter clock is not kept running
    stop_abort_w = stop_mode_in & ~aclk_q;
    sw_start_w   = sc_wr_w & ~ext_q & ~stop_abort_w;
    hw_start_w   = ext_q & trig_rise_w & ~stop_abort_w & ~halted_q;
    if (sc_wr_w) begin
      ien_d    = wb_dat_in[SC_IEN_BIT];
      cont_d   = wb_dat_in[SC_CONT_BIT];
      ch_d     = wb_dat_in[CH_W-1:0];
      halted_d = 1'b0;
    end
    if (wr_w && wb_adr_in == ADDR_CFG) begin
      aclk_d = wb_dat_in[CFG_ACLK_BIT];
      ext_d  = wb_dat_in[CFG_EXT_BIT];
    end
    if (wr_w && wb_adr_in == ADDR_ISTS) begin
      ists_d = ists_q & ~wb_dat_in[IST_W-1:0];
    end
    if (wr_w && wb_adr_in == ADDR_IMSK) begin
      imsk_d = wb_dat_in[IST_W-1:0];
    end
    if (sc_wr_w || resl_rd_w) begin
      flag_d = 1'b0;
    end
    case (st_q)
      ST_IDLE: begin
        if (sw_start_w || hw_start_w) begin
          tmr_start_w = 1'b1;
          st_d        = ST_CONV;
        end
      end
      ST_CONV: begin
        if (stop_abort_w) begin
          tmr_abort_w          = 1'b1;
          st_d                 = ST_IDLE;
          halted_d             = 1'b1;
          ists_d[IST_ABRT_BIT] = 1'b1;
        end else if (tmr_done_w) begin
          flag_d               = 1'b1;
          res_d                = sample_data_in;
          ists_d[IST_DONE_BIT] = 1'b1;
          if (cont_q && !ext_q && !sc_wr_w) begin
            tmr_start_w = 1'b1;
          end else if (sw_start_w) begin
            tmr_start_w = 1'b1;
          end else begin
            st_d = ST_IDLE;
          end
        end else if (sw_start_w) begin
          tmr_start_w = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    irq_d = (flag_d & ien_d) | (|(ists_d & imsk_d));
    lp_d  = (st_d == ST_IDLE);
    act_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      st_q     <= ST_IDLE;
      flag_q   <= 1'b0;
      ien_q    <= 1'b0;
      cont_q   <= 1'b0;
      ch_q     <= CH_RST;
      aclk_q   <= 1'b0;
      ext_q    <= 1'b0;
      halted_q <= 1'b0;
      ists_q   <= '0;
      imsk_q   <= IMSK_RST;
      res_q    <= '0;
      irq_q    <= 1'b0;
      lp_q     <= 1'b1;
      act_q    <= 1'b0;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
    end else begin
      st_q     <= st_d;
      flag_q   <= flag_d;
      ien_q    <= ien_d;
      cont_q   <= cont_d;
      ch_q     <= ch_d;
      aclk_q   <= aclk_d;
      ext_q    <= ext_d;
      halted_q <= halted_d;
      ists_q   <= ists_d;
      imsk_q   <= imsk_d;
      res_q    <= res_d;
      irq_q    <= irq_d;
      lp_q     <= lp_d;
      act_q    <= act_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
    end
  end

  assign wb_ack_out         = ack_q;
  assign wb_dat_out         = rdat_q;
  assign irq_out            = irq_q;
  assign low_power_out      = lp_q;
  assign conv_active_out    = act_q;
  assign channel_select_out = ch_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_flag_on_done;
    @(posedge clk_in) disable iff (!rst_b_q)
    (st_q == ST_CONV && tmr_done_w && !stop_abort_w) |=> flag_q;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done)
    else $error("flag not set after conversion end");

  property p_irq_follows;
    @(posedge clk_in) disable iff (!rst_b_q)
    (flag_q && ien_q) |-> irq_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt low while flag and enable set");

  property p_irq_quiet;
    @(posedge clk_in) disable iff (!rst_b_q)
    (!(flag_q && ien_q) && ((ists_q & imsk_q) == '0)) |-> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt high with no cause");

  property p_wait_runs;
    @(posedge clk_in) disable iff (!rst_b_q)
    (st_q == ST_CONV && wait_mode_in && !stop_mode_in && !tmr_done_w)
      |=> st_q == ST_CONV;
  endproperty
  a_wait_runs: assert property (p_wait_runs)
    else $error("conversion dropped in wait mode");

  property p_single_sleeps;
    @(posedge clk_in) disable iff (!rst_b_q)
    (st_q == ST_CONV && tmr_done_w && !cont_q && !sc_wr_w)
      |=> low_power_out && $stable(ch_q);
  endproperty
  a_single_sleeps: assert property (p_single_sleeps)
    else $error("single conversion did not enter low power");

  property p_stop_abort;
    @(posedge clk_in) disable iff (!rst_b_q)
    (st_q == ST_CONV && stop_mode_in && !aclk_q)
      |=> st_q == ST_IDLE && halted_q && low_power_out;
  endproperty
  a_stop_abort: assert property (p_stop_abort)
    else $error("stop did not abort the conversion");

  property p_halt_idle;
    @(posedge clk_in) disable iff (!rst_b_q)
    (halted_q && !sc_wr_w) |=> st_q == ST_IDLE;
  endproperty
  a_halt_idle: assert property (p_halt_idle)
    else $error("conversion resumed without control write");

  property p_result_hold;
    @(posedge clk_in) disable iff (!rst_b_q)
    !(st_q == ST_CONV && tmr_done_w) |=> $stable(res_q);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without a completed conversion");

  property p_async_stop_runs;
    @(posedge clk_in) disable iff (!rst_b_q)
    (st_q == ST_CONV && stop_mode_in && aclk_q && !tmr_done_w)
      |=> st_q == ST_CONV;
  endproperty
  a_async_stop_runs: assert property (p_async_stop_runs)
    else $error("conversion dropped in stop with async clock");

  property p_trigger_start;
    @(posedge clk_in) disable iff (!rst_b_q)
    (st_q == ST_IDLE && stop_mode_in && aclk_q && ext_q && trig_rise_w
      && !halted_q) |=> st_q == ST_CONV && conv_active_out;
  endproperty
  a_trigger_start: assert property (p_trigger_start)
    else $error("hardware trigger did not start a conversion");
endmodule
`default_nettype wire

// ---- rtl/alpic_pkg.sv ----
// package: constants and types of the converter control block
`default_nettype none
package alpic_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_SC    = 8'h00;
  localparam logic [7:0] ADDR_RESH  = 8'h04;
  localparam logic [7:0] ADDR_RESL  = 8'h08;
  localparam logic [7:0] ADDR_CFG   = 8'h0C;
  localparam logic [7:0] ADDR_ISTS  = 8'h10;
  localparam logic [7:0] ADDR_IMSK  = 8'h14;
  ////////////////////////////////////////////////////////////////////////////
  localparam int SC_FLAG_BIT  = 7;
  localparam int SC_IEN_BIT   = 6;
  localparam int SC_CONT_BIT  = 5;
  localparam int CH_W         = 5;
  localparam int CFG_ACLK_BIT = 0;
  localparam int CFG_EXT_BIT  = 1;
  localparam int IST_DONE_BIT = 0;
  localparam int IST_ABRT_BIT = 1;
  localparam int IST_W        = 2;
  localparam int RES_W        = 10;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [CH_W-1:0]  CH_RST   = 5'h1F;
  localparam logic [IST_W-1:0] IMSK_RST = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS  = 2000;
  localparam int CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} alpic_state_t;
endpackage
`default_nettype wire

// ---- rtl/alpic_conv_timer.sv ----
// module: conversion duration timer with start, abort and done pulse
`default_nettype none
module alpic_conv_timer
  import alpic_pkg::*;
#(
  parameter int CYCLES = 20
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  input  wire logic abort_in,
  output logic      busy_out,
  output logic      done_out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic          busy_q, busy_d;
  logic          done_q, done_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort_in) begin
      busy_d = 1'b0;
    end else if (start_in) begin
      busy_d = 1'b1;
      cnt_d  = '0;
    end else if (busy_q) begin
      if (cnt_q == LAST) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
endmodule
`default_nettype wire

// ---- dv/alpic_core_model.sv ----
// partner model: hardware conversion trigger and analog sample source
`default_nettype none
module alpic_core_model
  import alpic_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             fire_in,
  input  wire logic             alt_in,
  output logic                  trigger_out,
  output logic      [RES_W-1:0] sample_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold_q = 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  // pulse held long enough for the input synchroniser, low between pulses
  always_ff @(posedge clk_in) begin
    if (fire_in) begin
      hold_q <= 3'h6;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  assign trigger_out = (hold_q != 3'h0);
  assign sample_out  = alt_in ? 10'h15A : 10'h2A5;
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// testbench: register-level tests of the converter control block
`default_nettype none
module tb
  import alpic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rst_b, cyc, stb, we, wmode, smode, fire, alt;
  logic [7:0]       adr;
  logic [31:0]      wdat, rd, rdat;
  logic [3:0]       sel;
  logic             ack, irq, lp, act, trig;
  logic [CH_W-1:0]  ch;
  logic [RES_W-1:0] smp;
  int               fail_count, cmp_count, cyc_n;
  ////////////////////////////////////////////////////////////////////////////
  alpic_top DUT (
    .clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_ack_out(ack), .wb_dat_out(rdat), .wait_mode_in(wmode),
    .stop_mode_in(smode), .external_trigger_input_in(trig),
    .sample_data_in(smp), .irq_out(irq), .low_power_out(lp),
    .conv_active_out(act), .channel_select_out(ch)
  );
  alpic_core_model partner (
    .clk_in(clk), .fire_in(fire), .alt_in(alt),
    .trigger_out(trig), .sample_out(smp)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      fail_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk(32'(n), 32'h2);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_lp(input logic v);
    int n;
    n = 0;
    while (lp !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(32'(lp), 32'(v));
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0; rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h0; wdat = 32'h0; sel = 4'hF; wmode = 1'b0; smode = 1'b0;
    fire = 1'b0; alt = 1'b0; fail_count = 0; cmp_count = 0; cyc_n = 0;
    nap(6);
    rst_b <= 1'b1;
    nap(3);
    chk(32'(lp), 32'h1);
    chk(32'(act), 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(ch), 32'h1F);
    rdc(ADDR_SC, 32'h1F);
    rdc(ADDR_IMSK, 32'h0);
    rdc(8'hFC, 32'h0);
    // a write without the low byte lane is ignored
    sel <= 4'hE;
    wr(ADDR_IMSK, 32'h3);
    sel <= 4'hF;
    rdc(ADDR_IMSK, 32'h0);
    // single conversion, irq off, channel not all ones
    wr(ADDR_SC, 32'h3);
    nap(2);
    chk(32'(lp), 32'h0);
    chk(32'(act), 32'h1);
    wait_lp(1'b1);
    chk(32'(irq), 32'h0);
    chk(32'(ch), 32'h3);
    rdc(ADDR_SC, 32'h83);
    rdc(ADDR_RESH, 32'h2);
    rdc(ADDR_RESL, 32'hA5);
    rdc(ADDR_SC, 32'h3);
    // wait mode with irq enabled, continuous off first
    wmode <= 1'b1;
    wr(ADDR_SC, 32'h43);
    nap(2);
    wait_lp(1'b1);
    chk(32'(irq), 32'h1);
    rdc(ADDR_SC, 32'hC3);
    rdc(ADDR_RESL, 32'hA5);
    nap(2);
    chk(32'(irq), 32'h0);
    wmode <= 1'b0;
    // stop without async clock aborts mid conversion
    wr(ADDR_CFG, 32'h0);
    alt <= 1'b1;
    wr(ADDR_SC, 32'h3);
    nap(5);
    smode <= 1'b1;
    nap(3);
    chk(32'(lp), 32'h1);
    smode <= 1'b0;
    nap(30);
    chk(32'(lp), 32'h1);
    rdc(ADDR_RESL, 32'hA5);
    rdc(ADDR_ISTS, 32'h3);
    // sticky status and mask
    wr(ADDR_IMSK, 32'h2);
    nap(2);
    chk(32'(irq), 32'h1);
    wr(ADDR_ISTS, 32'h2);
    nap(2);
    chk(32'(irq), 32'h0);
    wr(ADDR_IMSK, 32'h3);
    nap(2);
    chk(32'(irq), 32'h1);
    wr(ADDR_ISTS, 32'h1);
    nap(2);
    chk(32'(irq), 32'h0);
    rdc(ADDR_ISTS, 32'h0);
    wr(ADDR_IMSK, 32'h0);
    // control write resumes conversions
    wr(ADDR_SC, 32'h3);
    nap(2);
    chk(32'(lp), 32'h0);
    wait_lp(1'b1);
    rdc(ADDR_RESL, 32'h5A);
    // continuous mode restarts with no idle gap
    wr(ADDR_SC, 32'h23);
    nap(50);
    chk(32'(lp), 32'h0);
    rdc(ADDR_SC, 32'hA3);
    wr(ADDR_SC, 32'h03);
    wait_lp(1'b1);
    // stop with async clock, external trigger mode
    wr(ADDR_CFG, 32'h3);
    wr(ADDR_SC, 32'h43);
    smode <= 1'b1;
    alt <= 1'b0;
    nap(10);
    chk(32'(lp), 32'h1);
    fire <= 1'b1;
    nap(1);
    fire <= 1'b0;
    wait_lp(1'b0);
    wait_lp(1'b1);
    chk(32'(irq), 32'h1);
    rdc(ADDR_RESL, 32'hA5);
    smode <= 1'b0;
    summarize();
  end
endmodule
`default_nettype wire
